// File: src/hcic_pkg.sv
// hcic_pkg: shared constants for the host cpu interface control block
// assumes both ends and the carrier interface compile after this package
`default_nettype none
package hcic_pkg;
    localparam int DATA_W = 64;
    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 3;
    localparam int SNOOP_LO = 5;
    localparam int BE_W = 8;
    localparam logic [15:0] PORT_FPU_CLR = 16'h00F0;
    localparam logic [15:0] PORT_SYS_CTL_A = 16'h0092;
    localparam logic [15:0] PORT_KBD_CMD = 16'h0064;
    localparam logic [7:0] KBD_RESET_CMD = 8'hFE;
    localparam int INIT_BIT = 0;
    localparam int RESUME_RST_BIT = 5;
    localparam logic [7:0] PINFN_CACHE_OE = 8'h00;
    localparam int INIT_PULSE_CYC = 4;
    localparam int RESET_PULSE_CYC = 16;
    // {m/io, d/c, w/r} codes
    localparam logic [2:0] CYC_INTA = 3'h0;
    localparam logic [2:0] CYC_SPECIAL = 3'h1;
    localparam logic [2:0] CYC_IO_RD = 3'h2;
    localparam logic [2:0] CYC_IO_WR = 3'h3;
    localparam logic [2:0] CYC_MEM_RD = 3'h6;
    localparam logic [2:0] CYC_MEM_WR = 3'h7;
    typedef enum logic [1:0] {
        HCIC_IDLE  = 2'h0,
        HCIC_XFER  = 2'h1,
        HCIC_SNOOP = 2'h3,
        HCIC_WBACK = 2'h2
    } hcic_state_t;
endpackage
`default_nettype wire

// File: src/hcic_if.sv
// hcic_if: processor bus between the controller and the processor end
// assumes one shared clock; two-way pins are resolved here from the enables
`default_nettype none
interface hcic_if (input wire logic clk);
    logic [63:0] dev_data_o, cpu_data_o, host_data_bus;
    logic [31:3] cpu_addr_o, host_address_lines;
    logic [31:5] dev_addr_o;
    logic [7:0]  byte_lane_selects_n;
    logic        dev_data_oe_n, cpu_data_oe_n, dev_addr_oe_n, dev_wr_oe_n;
    logic        addr_strobe_n, mem_io, data_ctl, wr_rd_o, wr_rd, lock_n;
    logic        l1_invalidate_out, burst_ready_n, next_addr_n;
    logic        cacheable_enable_n, ext_addr_strobe_n, addr_hold_out;
    logic        hit_modified_n, nmi_out, maskable_irq_out, fpu_error_in_n;
    logic        ignore_fpu_error_n, proc_init_out, proc_hard_reset;
    logic        sys_mgmt_irq_n, sys_mgmt_active_n, stop_clock_req_n;
    assign host_data_bus = !dev_data_oe_n ? dev_data_o :
                           !cpu_data_oe_n ? cpu_data_o : 64'h0;
    assign host_address_lines = !dev_addr_oe_n ?
                                {dev_addr_o, 2'h0} : cpu_addr_o;
    assign wr_rd = !dev_wr_oe_n ? l1_invalidate_out : wr_rd_o;
    modport dev (
        input  clk, host_data_bus, host_address_lines, byte_lane_selects_n,
               addr_strobe_n, mem_io, data_ctl, wr_rd, lock_n,
               hit_modified_n, fpu_error_in_n, sys_mgmt_active_n,
        output dev_data_o, dev_data_oe_n, dev_addr_o, dev_addr_oe_n,
               l1_invalidate_out, dev_wr_oe_n, burst_ready_n, next_addr_n,
               cacheable_enable_n, ext_addr_strobe_n, addr_hold_out,
               nmi_out, maskable_irq_out, ignore_fpu_error_n,
               proc_init_out, proc_hard_reset, sys_mgmt_irq_n,
               stop_clock_req_n
    );
    modport cpu (
        input  clk, host_data_bus, host_address_lines, burst_ready_n,
               next_addr_n, cacheable_enable_n, ext_addr_strobe_n,
               addr_hold_out, nmi_out, maskable_irq_out,
               ignore_fpu_error_n, proc_init_out, proc_hard_reset,
               sys_mgmt_irq_n, stop_clock_req_n, wr_rd,
        output cpu_data_o, cpu_data_oe_n, cpu_addr_o, byte_lane_selects_n,
               addr_strobe_n, mem_io, data_ctl, wr_rd_o, lock_n,
               hit_modified_n, fpu_error_in_n, sys_mgmt_active_n
    );
endinterface
`default_nettype wire

// File: src/hcic_dev.sv
// hcic_dev: controller end of the processor bus
// assumes the processor end follows the bus protocol; one clock domain
//
// Summary of operation
// - 64-bit two-way host data bus
// - address 31:3 input, decoded on processor cycles
// - drive address 31:5 during snoop inquiry
// - processor supplies eight active-low byte selects
// - nmi on parity error or channel check input low
// - interrupt request out while request pending
// - fpu error raises irq 13, arms ignore
// - ignore low after error and F0 write
// - init pulse on shutdown or 092 bit rise
// - keyboard FE init, or external reset input
// - decode cycle type; forward interrupt acknowledge
// - io and non-dram memory go to pci
// - write/read pin drives invalidate during snoop
// - processor strobes address with cycle definition
// - burst ready for read, write, special cycle
// - next address single clock for dram cycles
// - hold address, drive snoop, external strobe
// - hit modified leads to accepted writeback
// - locked cycle drives pci lock indication
// - hard reset on power good, optional resume
// - smi out, management active in, stop clock
// - pin function 00 selects cache oe
//
// Implementation choices: strobed register access and the register offsets.
`default_nettype none
module hcic_dev #(
    parameter logic [31:0] DRAM_TOP = 32'h0800_0000  // top of local dram
) (
    input  wire logic        CLK,               // 250 MHz clock
    input  wire logic        SYS_RST,           // sync reset, high
    hcic_if.dev              BUS,               // processor bus
    input  wire logic [63:0] RD_DATA,           // local read data
    input  wire logic        PARITY_ERR,        // local read parity error
    input  wire logic        CHANNEL_CHECK_N,   // expansion channel check
    input  wire logic        IRQ_PENDING,       // controller request pending
    input  wire logic        KEYBOARD_RESET_IN, // external keyboard reset
    input  wire logic        KBD_EMUL_EN,       // keyboard emulation enable
    input  wire logic        POWER_GOOD_IN,     // power good
    input  wire logic        RESUME_EVENT,      // resume from suspend pulse
    input  wire logic [7:0]  CFG_RESUME,        // config byte, bit 5 used
    input  wire logic [7:0]  PIN_FUNCTION,      // cache oe pin function
    input  wire logic        GENERAL_OUT_VAL,   // value as general output
    input  wire logic        SMI_REQ,           // request management mode
    input  wire logic        STOP_CLOCK_REQ,    // request stop clock
    input  wire logic        SNOOP_REQ,         // snoop request pulse
    input  wire logic [31:5] SNOOP_ADDR,        // snoop address
    input  wire logic        SNOOP_INV,         // invalidate on snoop
    output logic             PCI_FWD,           // cycle forwarded, pulse
    output logic             PCI_INTA,          // forwarded as int ack
    output logic [2:0]       PCI_CYC,           // forwarded cycle code
    output logic [31:3]      PCI_ADDR,          // forwarded address
    output logic             PCI_LOCK_N,        // pci lock indication
    output logic [63:0]      WR_DATA,           // captured write data
    output logic             WR_VALID,          // write data taken, pulse
    output logic             IRQ_LINE_13,       // coprocessor irq
    output logic             SMM_ACTIVE,        // processor in management
    output logic             WRITEBACK_PEND,    // snoop hit writeback due
    output logic             L2_OUTPUT_ENABLE_N, // cache oe / general out
    output logic             HIT_SEEN           // snoop hit latched
);
    hcic_pkg::hcic_state_t st_r;
    logic [2:0]  cyc_r;
    logic [31:3] adr_r;
    logic [7:0]  lanes_r;
    logic        is_dram_r, fpu_error_in_n_d_r, ign_r, p92_r, pg_d_r, kbd_d_r, na_done_r;
    logic [2:0]  init_cnt_r;
    logic [4:0]  rst_cnt_r;
    logic [1:0]  sn_ph_r;

    function automatic logic io_wr_to(input logic [2:0] c,
                                      input logic [31:3] a,
                                      input logic [15:0] port);
        io_wr_to = (c == hcic_pkg::CYC_IO_WR) &&
                   (a[15:3] == port[15:3]);
    endfunction

    function automatic logic [7:0] lane_byte(input logic [63:0] d,
                                             input logic [7:0] be_n);
        lane_byte = 8'h00;
        for (int k = 0; k < 8; k++) begin
            lane_byte |= be_n[k] ? 8'h00 : d[k*8 +: 8];
        end
    endfunction

    wire logic ads = !BUS.addr_strobe_n && (st_r == hcic_pkg::HCIC_IDLE);
    wire logic [2:0] cyc_in = {BUS.mem_io, BUS.data_ctl, BUS.wr_rd};
    wire logic in_dram = BUS.mem_io &&
                         ({BUS.host_address_lines, 3'h0} < DRAM_TOP);
    wire logic wr_take = (st_r == hcic_pkg::HCIC_XFER) && cyc_r[0];
    wire logic [7:0] wr_byte = lane_byte(BUS.host_data_bus, lanes_r);

    // transfer and snoop sequencing
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_r <= hcic_pkg::HCIC_IDLE;
            sn_ph_r <= 2'h0;
        end else begin
            case (st_r)
                hcic_pkg::HCIC_IDLE: begin
                    if (ads) begin
                        st_r <= hcic_pkg::HCIC_XFER;
                    end else if (SNOOP_REQ) begin
                        st_r <= hcic_pkg::HCIC_SNOOP;
                    end
                end
                hcic_pkg::HCIC_XFER: st_r <= hcic_pkg::HCIC_IDLE;
                hcic_pkg::HCIC_SNOOP: begin
                    sn_ph_r <= sn_ph_r + 2'h1;
                    if (sn_ph_r == 2'h3) begin
                        // hit: stay ready for the writeback cycle
                        st_r <= !BUS.hit_modified_n ?
                                hcic_pkg::HCIC_WBACK : hcic_pkg::HCIC_IDLE;
                    end
                end
                hcic_pkg::HCIC_WBACK: begin
                    if (!BUS.addr_strobe_n) begin
                        st_r <= hcic_pkg::HCIC_XFER;
                    end
                end
                default: st_r <= hcic_pkg::HCIC_IDLE;
            endcase
        end
    end

    // cycle capture and decode
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cyc_r <= 3'h0;
            adr_r <= '0;
            lanes_r <= 8'hFF;
            is_dram_r <= 1'b0;
        end else if (ads || (st_r == hcic_pkg::HCIC_WBACK &&
                             !BUS.addr_strobe_n)) begin
            cyc_r <= cyc_in;
            adr_r <= BUS.host_address_lines;
            lanes_r <= BUS.byte_lane_selects_n;
            is_dram_r <= in_dram;
        end
    end

    // forward to pci, handshakes
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PCI_FWD <= 1'b0;
            PCI_INTA <= 1'b0;
            PCI_CYC <= 3'h0;
            PCI_ADDR <= '0;
            WR_VALID <= 1'b0;
            WR_DATA <= '0;
            na_done_r <= 1'b0;
        end else begin
            PCI_FWD <= ads && !in_dram;
            PCI_INTA <= ads && (cyc_in == hcic_pkg::CYC_INTA);
            if (ads) begin
                PCI_CYC <= cyc_in;
                PCI_ADDR <= BUS.host_address_lines;
            end
            WR_VALID <= wr_take;
            if (wr_take) begin
                WR_DATA <= BUS.host_data_bus;
            end
            na_done_r <= ads && in_dram;
        end
    end

    // coprocessor error and ignore output
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fpu_error_in_n_d_r <= 1'b1;
            ign_r <= 1'b1;
            IRQ_LINE_13 <= 1'b0;
        end else begin
            fpu_error_in_n_d_r <= BUS.fpu_error_in_n;
            if (!BUS.fpu_error_in_n && fpu_error_in_n_d_r) begin
                IRQ_LINE_13 <= 1'b1;
            end else if (BUS.fpu_error_in_n) begin
                IRQ_LINE_13 <= 1'b0;
            end
            if (BUS.fpu_error_in_n) begin
                ign_r <= 1'b1;
            end else if (wr_take &&
                         io_wr_to(cyc_r, adr_r, hcic_pkg::PORT_FPU_CLR)) begin
                ign_r <= 1'b0;
            end
        end
    end

    // processor init and hard reset pulses
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            p92_r <= 1'b0;
            init_cnt_r <= 3'h0;
            kbd_d_r <= 1'b0;
            rst_cnt_r <= 5'h0;
            pg_d_r <= 1'b0;
        end else begin
            kbd_d_r <= KEYBOARD_RESET_IN;
            pg_d_r <= POWER_GOOD_IN;
            if (wr_take && io_wr_to(cyc_r, adr_r, hcic_pkg::PORT_SYS_CTL_A))
            begin
                p92_r <= wr_byte[hcic_pkg::INIT_BIT];
            end
            if ((wr_take && cyc_r == hcic_pkg::CYC_SPECIAL &&
                 lanes_r == 8'hFE)
                || (wr_take && !p92_r && wr_byte[hcic_pkg::INIT_BIT]
                    && io_wr_to(cyc_r, adr_r, hcic_pkg::PORT_SYS_CTL_A))
                || (KBD_EMUL_EN && wr_take &&
                    io_wr_to(cyc_r, adr_r, hcic_pkg::PORT_KBD_CMD) &&
                    wr_byte == hcic_pkg::KBD_RESET_CMD)
                || (!KBD_EMUL_EN && KEYBOARD_RESET_IN && !kbd_d_r)) begin
                init_cnt_r <= 3'(hcic_pkg::INIT_PULSE_CYC);
            end else if (init_cnt_r != 3'h0) begin
                init_cnt_r <= init_cnt_r - 3'h1;
            end
            if ((POWER_GOOD_IN && !pg_d_r) ||
                (RESUME_EVENT && CFG_RESUME[hcic_pkg::RESUME_RST_BIT])) begin
                rst_cnt_r <= 5'(hcic_pkg::RESET_PULSE_CYC);
            end else if (rst_cnt_r != 5'h0) begin
                rst_cnt_r <= rst_cnt_r - 5'h1;
            end
        end
    end

    // registered side outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PCI_LOCK_N <= 1'b1;
            SMM_ACTIVE <= 1'b0;
            WRITEBACK_PEND <= 1'b0;
            HIT_SEEN <= 1'b0;
            L2_OUTPUT_ENABLE_N <= 1'b1;
        end else begin
            PCI_LOCK_N <= BUS.lock_n;
            SMM_ACTIVE <= !BUS.sys_mgmt_active_n;
            WRITEBACK_PEND <= st_r == hcic_pkg::HCIC_WBACK;
            if (st_r == hcic_pkg::HCIC_SNOOP && sn_ph_r == 2'h3) begin
                HIT_SEEN <= !BUS.hit_modified_n;
            end
            // general mode is output only; no input path exists
            L2_OUTPUT_ENABLE_N <= (PIN_FUNCTION == hcic_pkg::PINFN_CACHE_OE)
                ? !(st_r == hcic_pkg::HCIC_XFER && is_dram_r && !cyc_r[0])
                : GENERAL_OUT_VAL;
        end
    end

    wire logic snooping = st_r == hcic_pkg::HCIC_SNOOP;
    assign BUS.addr_hold_out = snooping;
    assign BUS.dev_addr_o = SNOOP_ADDR;
    assign BUS.dev_addr_oe_n = !(snooping && sn_ph_r != 2'h0);
    assign BUS.ext_addr_strobe_n = !(snooping && sn_ph_r == 2'h1);
    assign BUS.l1_invalidate_out = SNOOP_INV;
    assign BUS.dev_wr_oe_n = BUS.dev_addr_oe_n;
    assign BUS.dev_data_o = RD_DATA;
    assign BUS.dev_data_oe_n = !(st_r == hcic_pkg::HCIC_XFER && !cyc_r[0]);
    assign BUS.burst_ready_n = !(st_r == hcic_pkg::HCIC_XFER);
    assign BUS.next_addr_n = !na_done_r;
    assign BUS.cacheable_enable_n = !(st_r == hcic_pkg::HCIC_XFER &&
                                      is_dram_r);
    assign BUS.nmi_out = PARITY_ERR || !CHANNEL_CHECK_N;
    assign BUS.maskable_irq_out = IRQ_PENDING;
    assign BUS.ignore_fpu_error_n = ign_r;
    assign BUS.proc_init_out = init_cnt_r != 3'h0;
    assign BUS.proc_hard_reset = rst_cnt_r != 5'h0;
    assign BUS.sys_mgmt_irq_n = !SMI_REQ;
    assign BUS.stop_clock_req_n = !STOP_CLOCK_REQ;
endmodule
`default_nettype wire

// File: src/hcic_cpu.sv
// hcic_cpu: processor end of the bus, driven by a simple user port
// assumes the controller end answers every cycle with burst ready
`default_nettype none
module hcic_cpu (
    input  wire logic        CLK,        // 250 MHz clock
    input  wire logic        SYS_RST,    // sync reset, high
    hcic_if.cpu              BUS,        // processor bus
    input  wire logic        REQ,        // start a cycle, pulse
    input  wire logic [2:0]  REQ_CYC,    // {m/io, d/c, w/r}
    input  wire logic [31:3] REQ_ADDR,   // cycle address
    input  wire logic [7:0]  REQ_BE_N,   // byte lane selects
    input  wire logic [63:0] REQ_WDATA,  // write data
    input  wire logic        REQ_LOCK,   // lock this cycle
    input  wire logic        FPU_ERR,    // coprocessor error level
    input  wire logic        L1_MOD_HIT, // answer snoops with a hit
    output logic             BUSY,       // cycle outstanding
    output logic [63:0]      RDATA,      // read data
    output logic             DONE,       // cycle ended, pulse
    output logic             IN_SMM,     // management mode level
    output logic             SNOOP_INV_SEEN // invalidate seen on snoop
);
    logic        ads_r;
    logic [2:0]  cyc_r;
    logic [31:3] adr_r;
    logic [7:0]  be_r;
    logic [63:0] wd_r;
    logic        hit_modified_n_r;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ads_r <= 1'b0;
            BUSY <= 1'b0;
            cyc_r <= 3'h0;
            adr_r <= '0;
            be_r <= 8'hFF;
            wd_r <= '0;
            DONE <= 1'b0;
            RDATA <= '0;
        end else begin
            ads_r <= REQ && !BUSY && !BUS.addr_hold_out;
            DONE <= 1'b0;
            if (REQ && !BUSY && !BUS.addr_hold_out) begin
                BUSY <= 1'b1;
                cyc_r <= REQ_CYC;
                adr_r <= REQ_ADDR;
                be_r <= REQ_BE_N;
                wd_r <= REQ_WDATA;
            end else if (BUSY && !ads_r && !BUS.burst_ready_n) begin
                BUSY <= 1'b0;
                DONE <= 1'b1;
                RDATA <= BUS.host_data_bus;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hit_modified_n_r <= 1'b1;
            IN_SMM <= 1'b0;
            SNOOP_INV_SEEN <= 1'b0;
        end else begin
            if (!BUS.ext_addr_strobe_n) begin
                hit_modified_n_r <= !L1_MOD_HIT;
                SNOOP_INV_SEEN <= BUS.wr_rd;
            end else if (ads_r) begin
                hit_modified_n_r <= 1'b1;
            end
            if (!BUS.sys_mgmt_irq_n) begin
                IN_SMM <= 1'b1;
            end
        end
    end

    assign BUS.addr_strobe_n = !ads_r;
    assign BUS.cpu_addr_o = adr_r;
    assign BUS.byte_lane_selects_n = be_r;
    assign BUS.mem_io = cyc_r[2];
    assign BUS.data_ctl = cyc_r[1];
    assign BUS.wr_rd_o = cyc_r[0];
    assign BUS.lock_n = !(REQ_LOCK && BUSY);
    assign BUS.cpu_data_o = wd_r;
    assign BUS.cpu_data_oe_n = !(BUSY && cyc_r[0] && !BUS.addr_hold_out);
    assign BUS.hit_modified_n = hit_modified_n_r;
    assign BUS.fpu_error_in_n = !FPU_ERR;
    assign BUS.sys_mgmt_active_n = !IN_SMM;
endmodule
`default_nettype wire

// File: verification/hcic_assertions.sv
// hcic_assertions: bus protocol checks between controller and processor end
// assumes one clock and a synchronous active-high reset; no bind, instantiated
`default_nettype none
module hcic_assertions (
    input wire logic        clk,                // bus clock
    input wire logic        sys_rst,            // sync reset, high
    input wire logic        addr_strobe_n,      // cycle start
    input wire logic        burst_ready_n,      // cycle answer
    input wire logic        next_addr_n,        // pipelined address ok
    input wire logic        addr_hold_out,      // snoop address hold
    input wire logic        ext_addr_strobe_n,  // snoop strobe
    input wire logic        dev_addr_oe_n,      // controller drives address
    input wire logic        dev_wr_oe_n,        // controller drives w/r pin
    input wire logic        dev_data_oe_n,      // controller drives data
    input wire logic        cpu_data_oe_n,      // processor drives data
    input wire logic        fpu_error_in_n,     // coprocessor error
    input wire logic        ignore_fpu_error_n, // ignore error out
    input wire logic        proc_init_out,      // init pulse
    input wire logic        proc_hard_reset     // hard reset pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    burst_ready_n_after_ads_a:
        assert property (!addr_strobe_n && burst_ready_n && !addr_hold_out
            |=> !burst_ready_n) else $error("cycle not answered");
    burst_ready_n_needs_ads_a:
        assert property (!burst_ready_n |-> $past(addr_strobe_n) == 1'b0)
            else $error("burst ready without a cycle");
    na_single_a:
        assert property (!next_addr_n |=> next_addr_n)
            else $error("next address longer than one clock");
    snoop_order_a:
        assert property ($rose(addr_hold_out) |=> !dev_addr_oe_n
            && !ext_addr_strobe_n) else $error("snoop address not driven");
    snoop_addr_hold_a:
        assert property (!dev_addr_oe_n |-> addr_hold_out)
            else $error("address driven without hold");
    snoop_inv_pin_a:
        assert property (!ext_addr_strobe_n |-> !dev_wr_oe_n)
            else $error("invalidate not driven during inquiry");
    data_one_driver_a:
        assert property (!dev_data_oe_n |-> cpu_data_oe_n)
            else $error("data bus driven by both ends");
    ignore_idle_a:
        assert property (fpu_error_in_n [*2] |-> ignore_fpu_error_n)
            else $error("ignore error low without error");
    init_pulse_a:
        assert property ($rose(proc_init_out) |-> ##3 proc_init_out
            ##1 !proc_init_out) else $error("init pulse length wrong");
    hard_reset_a:
        assert property ($rose(proc_hard_reset) |-> ##15 proc_hard_reset
            ##1 !proc_hard_reset) else $error("hard reset length wrong");
endmodule
`default_nettype wire

// File: verification/host_cpu_interface_control_test.sv
// host_cpu_interface_control_test: both bus ends joined, user sides driven
// assumes the default dram split; the bus is watched at the falling edge
`default_nettype none
module host_cpu_interface_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, req = 0, req_lock = 0, fpu_err = 0, mod_hit = 0;
    logic par_err = 0, chk_n = 1, irq_pend = 0, kbd_rst = 0, kbd_emul = 1;
    logic pwr_good = 0, resume = 0, gen_val = 0, smi_req = 0, stop_req = 0;
    logic snp_req = 0, snp_inv = 0, pci_fwd, pci_inta, pci_lock_n, wr_valid;
    logic irq_line_13, smm_act, wb_pend, l2_oe_n, hit_seen, busy, done, in_smm;
    logic inv_seen, init_q = 0, hrst_q = 0;
    logic [63:0] rd_data = 64'h0, req_wdata = 64'h0, wr_data, rdata;
    logic [7:0]  cfg_res = 8'h00, pin_fn = 8'h00, req_be_n = 8'hFF;
    logic [31:5] snp_addr = 27'h0, snp_seen = 27'h0;
    logic [31:3] req_addr = 29'h0, pci_addr;
    logic [2:0]  req_cyc = 3'h0, pci_cyc;
    logic [2:0]  tab [4] = '{hcic_pkg::CYC_INTA, hcic_pkg::CYC_IO_RD,
                             hcic_pkg::CYC_IO_WR, hcic_pkg::CYC_MEM_WR};
    int n_mismatch = 0, num_checks = 0, n_init = 0, n_hrst = 0, n_fwd = 0;
    int n_na = 0, n_lock = 0, n_inta = 0, i;
    initial forever #2 clk = ~clk;
    hcic_if bus (.clk(clk));
    hcic_dev hcic_dev_inst (.CLK(clk), .SYS_RST(rst), .BUS(bus),
        .RD_DATA(rd_data), .PARITY_ERR(par_err), .CHANNEL_CHECK_N(chk_n),
        .IRQ_PENDING(irq_pend), .KEYBOARD_RESET_IN(kbd_rst),
        .KBD_EMUL_EN(kbd_emul), .POWER_GOOD_IN(pwr_good),
        .RESUME_EVENT(resume), .CFG_RESUME(cfg_res), .PIN_FUNCTION(pin_fn),
        .GENERAL_OUT_VAL(gen_val), .SMI_REQ(smi_req),
        .STOP_CLOCK_REQ(stop_req), .SNOOP_REQ(snp_req),
        .SNOOP_ADDR(snp_addr), .SNOOP_INV(snp_inv), .PCI_FWD(pci_fwd),
        .PCI_INTA(pci_inta), .PCI_CYC(pci_cyc), .PCI_ADDR(pci_addr),
        .PCI_LOCK_N(pci_lock_n), .WR_DATA(wr_data), .WR_VALID(wr_valid),
        .IRQ_LINE_13(irq_line_13), .SMM_ACTIVE(smm_act),
        .WRITEBACK_PEND(wb_pend), .L2_OUTPUT_ENABLE_N(l2_oe_n),
        .HIT_SEEN(hit_seen));
    hcic_cpu hcic_cpu_inst (.CLK(clk), .SYS_RST(rst), .BUS(bus), .REQ(req),
        .REQ_CYC(req_cyc), .REQ_ADDR(req_addr), .REQ_BE_N(req_be_n),
        .REQ_WDATA(req_wdata), .REQ_LOCK(req_lock), .FPU_ERR(fpu_err),
        .L1_MOD_HIT(mod_hit), .BUSY(busy), .RDATA(rdata), .DONE(done),
        .IN_SMM(in_smm), .SNOOP_INV_SEEN(inv_seen));
    hcic_assertions hcic_assertions_inst (.clk(clk), .sys_rst(rst),
        .addr_strobe_n(bus.addr_strobe_n), .burst_ready_n(bus.burst_ready_n),
        .next_addr_n(bus.next_addr_n), .addr_hold_out(bus.addr_hold_out),
        .ext_addr_strobe_n(bus.ext_addr_strobe_n),
        .dev_addr_oe_n(bus.dev_addr_oe_n), .dev_wr_oe_n(bus.dev_wr_oe_n),
        .dev_data_oe_n(bus.dev_data_oe_n), .cpu_data_oe_n(bus.cpu_data_oe_n),
        .fpu_error_in_n(bus.fpu_error_in_n),
        .ignore_fpu_error_n(bus.ignore_fpu_error_n),
        .proc_init_out(bus.proc_init_out),
        .proc_hard_reset(bus.proc_hard_reset));
    // counted at the falling edge so registered outputs have settled
    always @(negedge clk) begin
        init_q <= bus.proc_init_out;
        hrst_q <= bus.proc_hard_reset;
        n_init += int'(bus.proc_init_out === 1'b1 && !init_q);
        n_hrst += int'(bus.proc_hard_reset === 1'b1 && !hrst_q);
        n_fwd += int'(pci_fwd === 1'b1);
        n_inta += int'(pci_inta === 1'b1);
        n_na += int'(bus.next_addr_n === 1'b0);
        n_lock += int'(pci_lock_n === 1'b0);
        if (bus.ext_addr_strobe_n === 1'b0)
            snp_seen <= bus.host_address_lines[31:5];
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic cyc(input logic [2:0] c, input logic [31:3] a,
                       input logic [7:0] be, input logic [63:0] d);
        int k;
        @(posedge clk);
        req <= 1'b1;
        req_cyc <= c;
        req_addr <= a;
        req_be_n <= be;
        req_wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        for (k = 0; k < 50 && done !== 1'b1; k++) @(negedge clk);
        if (k >= 50) begin
            n_mismatch++;
            end_of_test();
        end
        step(6);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        step(1);
        chk(bus.ignore_fpu_error_n, 1);
        rd_data <= 64'h0123_4567_89AB_CDEF;
        cyc(hcic_pkg::CYC_MEM_RD, 29'h0000200, 8'h00, 64'h0);
        chk(rdata, 64'h0123_4567_89AB_CDEF);
        chk({n_fwd, n_na}, {32'd0, 32'd1});
        req_lock <= 1'b1;
        for (i = 0; i < 4; i++) begin
            cyc(tab[i], 29'h1200000, 8'h0F, 64'h5A5A_0000_A5A5_FFFF);
            chk({pci_cyc, pci_addr}, {tab[i], 29'h1200000});
        end
        chk({n_fwd, n_inta}, {32'd4, 32'd1});
        chk(n_lock > 0, 1);
        chk(wr_data, 64'h5A5A_0000_A5A5_FFFF);
        req_lock <= 1'b0;
        cyc(hcic_pkg::CYC_SPECIAL, 29'h0, 8'hFE, 64'h0);
        chk(n_init, 1);
        for (i = 0; i < 3; i++)
            cyc(hcic_pkg::CYC_IO_WR, 29'h12, 8'hFB, 64'(i != 0) << 16);
        chk(n_init, 2);
        cyc(hcic_pkg::CYC_IO_WR, 29'h0C, 8'hEF, 64'hFE << 32);
        chk(n_init, 3);
        kbd_emul <= 1'b0;
        cyc(hcic_pkg::CYC_IO_WR, 29'h0C, 8'hEF, 64'hFE << 32);
        kbd_rst <= 1'b1;
        step(6);
        chk(n_init, 4);
        fpu_err <= 1'b1;
        step(3);
        chk({irq_line_13, bus.ignore_fpu_error_n}, 2'h3);
        cyc(hcic_pkg::CYC_IO_WR, 29'h1E, 8'hFE, 64'h0);
        chk(bus.ignore_fpu_error_n, 0);
        fpu_err <= 1'b0;
        par_err <= 1'b1;
        irq_pend <= 1'b1;
        smi_req <= 1'b1;
        stop_req <= 1'b1;
        pin_fn <= 8'h80;
        gen_val <= 1'b1;
        step(4);
        chk({irq_line_13, bus.ignore_fpu_error_n, bus.nmi_out}, 3'h3);
        chk({bus.maskable_irq_out, bus.sys_mgmt_irq_n}, 2'h2);
        chk({bus.stop_clock_req_n, smm_act, in_smm, l2_oe_n}, 4'h7);
        par_err <= 1'b0;
        chk_n <= 1'b0;
        gen_val <= 1'b0;
        step(2);
        chk({bus.nmi_out, l2_oe_n}, 2'h2);
        chk_n <= 1'b1;
        step(2);
        chk(bus.nmi_out, 0);
        pwr_good <= 1'b1;
        step(20);
        for (i = 0; i < 2; i++) begin
            cfg_res <= 8'(i) << 5;
            resume <= 1'b1;
            step(0);
            resume <= 1'b0;
            step(20);
        end
        chk(n_hrst, 2);
        mod_hit <= 1'b1;
        snp_inv <= 1'b1;
        snp_addr <= 27'h1234567;
        snp_req <= 1'b1;
        step(0);
        snp_req <= 1'b0;
        step(10);
        chk(snp_seen, 27'h1234567);
        chk({hit_seen, wb_pend, inv_seen}, 3'h7);
        end_of_test();
    end
endmodule
`default_nettype wire
